// *** verilog/ubm_defs.svh ***
// Constants of the bus cycle break matcher: offsets, fields, resets.
// Assumes inclusion by the package and the top module only.
`ifndef UBM_DEFS_SVH
`define UBM_DEFS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define UBM_IDX_ADDR_HI   4'h0
`define UBM_IDX_ADDR_LO   4'h2
`define UBM_IDX_MASK_HI   4'h4
`define UBM_IDX_MASK_LO   4'h6
`define UBM_IDX_COND      4'h8
`define UBM_IDX_STATUS    4'hA

// ==========================================================
// Reset values
`define UBM_RST_HALF      16'h0000
`define UBM_RST_COND      8'h00

// ==========================================================
// Condition field positions
`define UBM_MST_MSB       7
`define UBM_MST_LSB       6
`define UBM_ACC_MSB       5
`define UBM_ACC_LSB       4
`define UBM_DIR_MSB       3
`define UBM_DIR_LSB       2
`define UBM_SIZE_MSB      1
`define UBM_SIZE_LSB      0

// ==========================================================
// Operand sizes and priority
`define UBM_SIZE_ANY      2'h0
`define UBM_SIZE_WORD     2'h2
`define UBM_BREAK_LEVEL   4'hF
`define UBM_FETCH_STEP    32'h0000_0002

`endif

// *** verilog/ubm_pkg.sv ***
// Types shared by the bus cycle break matcher.
// Assumes ubm_defs.svh is on the include path.
package ubm_pkg;
  `include "ubm_defs.svh"

  // Gray codes along idle, pending, forward
  typedef enum logic [1:0] {
    UBM_BRK_IDLE = 2'h0,
    UBM_BRK_PEND = 2'h1,
    UBM_BRK_FWD  = 2'h3
  } ubm_brk_e;

  typedef struct packed {
    logic [15:0] addr_hi;
    logic [15:0] addr_lo;
    logic [15:0] mask_hi;
    logic [15:0] mask_lo;
    logic [7:0]  cond;
    ubm_brk_e    brk;
    logic        second;
    logic        cpu_brk;
    logic        waitreq;
    logic [31:0] rdata;
  } ubm_state_s;
endpackage : ubm_pkg

// *** verilog/ubm_top.sv ***
// Bus cycle break matcher: watches processor and DMA bus cycles,
// raises a user break request and forwards it when accepted.
// Assumes bus cycle inputs synchronous to i_sys_clk, Avalon-MM master.
//
// Notes on behaviour
// [R01] Mask bit 1 drops that address bit from comparison; 0 needs exact match.
// [R02] High mask governs address bits 31..16, low mask bits 15..0.
// [R03] Reset clears both mask halves; standby keeps them.
// [R04] Reset clears the condition register; standby keeps it.
// [R05] Condition bits 15..8 read zero; software writes zeros there.
// [R06] Master field: 00 off, 01 processor, 10 DMA, 11 both.
// [R07] Access field: 00 off, 01 fetch, 10 data, 11 both.
// [R08] Direction field: 00 off, 01 read, 10 write, 11 both.
// [R09] Size field: 00 any, 01 byte, 10 word, 11 long.
// [R10] Any of master, access, direction at 00 blocks every break.
// [R11] Software keeps low size bit zero when breaking on fetches.
// [R12] Fetches count as word; data size comes from operand size.
// [R13] Full match raises the user break request to the controller.
// [R14] Request has priority 15; accepted only at mask level 14 or below.
// [R15] At mask level 15 the request stays pending until accepted.
// [R16] Non-maskable entry sets level 15, blocking breaks in its handler.
// [R17] Accepted request is forwarded to the processor as a break.
// [R18] Dual fetch: address of second instruction matches it; break after first.
// [R19] Address pair holds 32-bit break address, high half bits 31..16.
// [R20] Fetch break takes effect before the fetched instruction executes.
// [R21] Match is AND of masked address and every enabled field condition.
`timescale 1ns/1ps
`include "ubm_defs.svh"

module ubm_top
  import ubm_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_resetn,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] i_address,
  input  wire logic              i_read,
  input  wire logic              i_write,
  input  wire logic [3:0]        i_byteenable,
  input  wire logic [31:0]       i_writedata,
  output logic [31:0]            o_readdata,
  output logic                   o_waitrequest,
  // Observed bus cycle
  input  wire logic              i_cyc_valid,
  input  wire logic [31:0]       i_cyc_addr,
  input  wire logic              i_cyc_dma,
  input  wire logic              i_cyc_fetch,
  input  wire logic              i_cyc_write,
  input  wire logic [1:0]        i_cyc_size,
  input  wire logic              i_cyc_dual,
  // Processor state
  input  wire logic [3:0]        i_mask_level,
  input  wire logic              i_standby,
  // Break outputs
  output logic                   o_break_req,
  output logic                   o_cpu_break,
  output logic                   o_break_second
);

  // ==========================================================
  // Register map and timing
  //
  // Byte address is four times the register index.
  // 0x00 break address, high half (bits 31..16)
  // 0x08 break address, low half (bits 15..0)
  // 0x10 address mask, high half
  // 0x18 address mask, low half
  // 0x20 cycle conditions, bits 7..0 only
  // 0x28 status: bit 0 pending, bit 1 second hit
  // Anything else, or an offset off a word boundary,
  // reads zero and ignores writes; no bus error.
  //
  // Only byte enables 1..0 are used; the upper
  // lanes carry nothing, no register is over 16 bits.
  //
  // Every access takes two cycles: the request is
  // seen with waitrequest high, waitrequest drops
  // for one cycle, and a write lands on the edge
  // that closes that cycle. Read data is registered
  // in the same step, so it stands while waitrequest
  // is low and until the next read or write is answered.
  //
  // Mask bit set means that address bit is a
  // don't-care; a fully masked address matches all.
  // Unused select codes leave the matcher silent,
  // which is the state after reset.
  //
  // Break flow, one cycle per step:
  //  c0 bus cycle matches every enabled field
  //  c1 request raised toward the controller
  //  c2 request dropped, forward pulse high,
  //     unless the mask level sits at 15
  //  c3 forward pulse low again
  // A match during the pulse re-arms the request
  // at once, so back-to-back breaks are not lost.
  // Further matches while pending are absorbed:
  // the controller sees one request, not a count.
  //
  // Limitation: status bits are a view for debug
  // software; they clear only through the forward
  // step, never by a register write.
  //
  // Standby is deliberately not wired to any
  // state: settings must survive it, and only
  // reset may clear them.

  // ==========================================================
  // Helpers

  // Master select: 01 processor, 10 DMA, 11 both
  function automatic logic master_hit(input logic [1:0] sel,
                                      input logic       dma);
    case (sel)
      2'h1:    master_hit = ~dma;
      2'h2:    master_hit = dma;
      2'h3:    master_hit = 1'b1;
      default: master_hit = 1'b0;
    endcase
  endfunction : master_hit

  // Access select: 01 fetch, 10 data, 11 both
  function automatic logic access_hit(input logic [1:0] sel,
                                      input logic       fetch);
    case (sel)
      2'h1:    access_hit = fetch;
      2'h2:    access_hit = ~fetch;
      2'h3:    access_hit = 1'b1;
      default: access_hit = 1'b0;
    endcase
  endfunction : access_hit

  // Direction select: 01 read, 10 write, 11 both
  function automatic logic dir_hit(input logic [1:0] sel,
                                   input logic       wr);
    case (sel)
      2'h1:    dir_hit = ~wr;
      2'h2:    dir_hit = wr;
      2'h3:    dir_hit = 1'b1;
      default: dir_hit = 1'b0;
    endcase
  endfunction : dir_hit

  // Size select: 00 any size, else exact encoding
  function automatic logic size_hit(input logic [1:0] sel,
                                    input logic [1:0] size);
    case (sel)
      `UBM_SIZE_ANY: size_hit = 1'b1;
      default:       size_hit = sel == size;
    endcase
  endfunction : size_hit

  function automatic logic addr_ok(input logic [31:0] brk_addr,
                                   input logic [31:0] mask,
                                   input logic [31:0] addr);
    addr_ok = ((brk_addr ^ addr) & ~mask) == 32'h0000_0000; // [R01]
  endfunction : addr_ok

  function automatic logic [15:0] merge_be(input logic [15:0] old,
                                           input logic [15:0] wdat,
                                           input logic [1:0]  be);
    merge_be = {be[1] ? wdat[15:8] : old[15:8],
                be[0] ? wdat[7:0]  : old[7:0]};
  endfunction : merge_be

  // ==========================================================
  // State

  ubm_state_s s_q;
  ubm_state_s s_d;

  logic [31:0] brk_addr;
  logic [31:0] brk_mask;
  logic [1:0]  eff_size;
  logic        field_ok;
  logic        hit_first;
  logic        hit_second;
  logic        match;
  logic        accept;
  logic [3:0]  idx;
  logic        idx_hit;
  logic [31:0] rd_val;
  logic [15:0] cur_half;
  logic        mst_ok;
  logic        acc_ok;
  logic        dir_ok;
  logic        size_ok;
  logic        wr_go;
  logic        wr_addr_hi;
  logic        wr_addr_lo;
  logic        wr_mask_hi;
  logic        wr_mask_lo;
  logic        wr_cond;

  assign brk_addr = {s_q.addr_hi, s_q.addr_lo}; // [R19]
  assign brk_mask = {s_q.mask_hi, s_q.mask_lo}; // [R02]
  assign idx      = i_address[5:2];
  assign idx_hit  = i_address[1:0] == 2'h0;

  // ==========================================================
  // Break condition

  always_comb begin
    // Fetches are words even when two arrive at once
    eff_size = i_cyc_fetch ? `UBM_SIZE_WORD : i_cyc_size; // [R12]
    // A 00 master, access or direction field blocks every cycle; size 00 is any
    mst_ok   = master_hit(s_q.cond[`UBM_MST_MSB:`UBM_MST_LSB], i_cyc_dma);   // [R06] [R10]
    acc_ok   = access_hit(s_q.cond[`UBM_ACC_MSB:`UBM_ACC_LSB], i_cyc_fetch); // [R07] [R10]
    dir_ok   = dir_hit(s_q.cond[`UBM_DIR_MSB:`UBM_DIR_LSB], i_cyc_write);    // [R08] [R10]
    size_ok  = size_hit(s_q.cond[`UBM_SIZE_MSB:`UBM_SIZE_LSB], eff_size);    // [R09]
    field_ok = mst_ok & acc_ok & dir_ok & size_ok;
    hit_first  = addr_ok(brk_addr, brk_mask, i_cyc_addr);
    // Second instruction of a dual fetch sits one word above
    hit_second = i_cyc_fetch & i_cyc_dual
               & addr_ok(brk_addr, brk_mask, i_cyc_addr + `UBM_FETCH_STEP); // [R18]
    match = i_cyc_valid & field_ok & (hit_first | hit_second); // [R21]
    // Level 15 holds the request; NMI entry raises the level there
    accept = i_mask_level < `UBM_BREAK_LEVEL; // [R14] [R16]
  end

  // ==========================================================
  // Register readback

  always_comb begin
    rd_val = 32'h0000_0000;
    case (idx)
      `UBM_IDX_ADDR_HI: rd_val = {16'h0000, s_q.addr_hi};
      `UBM_IDX_ADDR_LO: rd_val = {16'h0000, s_q.addr_lo};
      `UBM_IDX_MASK_HI: rd_val = {16'h0000, s_q.mask_hi};
      `UBM_IDX_MASK_LO: rd_val = {16'h0000, s_q.mask_lo};
      `UBM_IDX_COND:    rd_val = {24'h00_0000, s_q.cond}; // [R05]
      `UBM_IDX_STATUS:  rd_val = {30'h0000_0000, s_q.second, o_break_req};
      default:          rd_val = 32'h0000_0000;
    endcase
    if (!idx_hit) begin
      rd_val = 32'h0000_0000;
    end
  end

  // ==========================================================
  // Write decode

  // One strobe per register keeps address decode out of next state
  always_comb begin
    wr_go      = i_write & ~s_q.waitreq & idx_hit;
    wr_addr_hi = 1'b0;
    wr_addr_lo = 1'b0;
    wr_mask_hi = 1'b0;
    wr_mask_lo = 1'b0;
    wr_cond    = 1'b0;
    case (idx)
      `UBM_IDX_ADDR_HI: wr_addr_hi = wr_go;
      `UBM_IDX_ADDR_LO: wr_addr_lo = wr_go;
      `UBM_IDX_MASK_HI: wr_mask_hi = wr_go;
      `UBM_IDX_MASK_LO: wr_mask_lo = wr_go;
      `UBM_IDX_COND:    wr_cond    = wr_go;
      default:          wr_cond    = 1'b0;
    endcase
  end

  // ==========================================================
  // Next state

  always_comb begin
    s_d         = s_q;
    s_d.cpu_brk = 1'b0;
    cur_half    = 16'h0000;

    // One wait cycle per request, then release for one cycle
    if ((i_read | i_write) & s_q.waitreq) begin
      s_d.waitreq = 1'b0;
      s_d.rdata   = i_read ? rd_val : 32'h0000_0000;
    end else begin
      s_d.waitreq = 1'b1;
    end

    // Standby never touches the settings; only reset clears them
    if (wr_addr_hi) begin // [R19]
      s_d.addr_hi = merge_be(s_q.addr_hi, i_writedata[15:0], i_byteenable[1:0]);
    end
    if (wr_addr_lo) begin // [R19]
      s_d.addr_lo = merge_be(s_q.addr_lo, i_writedata[15:0], i_byteenable[1:0]);
    end
    if (wr_mask_hi) begin // [R03]
      s_d.mask_hi = merge_be(s_q.mask_hi, i_writedata[15:0], i_byteenable[1:0]);
    end
    if (wr_mask_lo) begin // [R03]
      s_d.mask_lo = merge_be(s_q.mask_lo, i_writedata[15:0], i_byteenable[1:0]);
    end
    if (wr_cond) begin // [R04]
      // Upper byte is dropped so it always reads zero
      cur_half = merge_be({8'h00, s_q.cond}, i_writedata[15:0], i_byteenable[1:0]);
      s_d.cond = cur_half[7:0]; // [R05]
    end

    case (s_q.brk)
      UBM_BRK_IDLE: begin
        if (match) begin
          s_d.brk    = UBM_BRK_PEND; // [R13]
          s_d.second = hit_second & ~hit_first;
        end
      end
      UBM_BRK_PEND: begin
        // Stays pending while masked, never dropped
        if (accept) begin // [R15]
          s_d.brk     = UBM_BRK_FWD;
          s_d.cpu_brk = 1'b1; // [R17] [R20]
        end
      end
      UBM_BRK_FWD: begin
        // A match in this cycle wins over the clear
        if (match) begin
          s_d.brk    = UBM_BRK_PEND;
          s_d.second = hit_second & ~hit_first;
        end else begin
          s_d.brk    = UBM_BRK_IDLE;
          s_d.second = 1'b0;
        end
      end
      default: s_d.brk = UBM_BRK_IDLE;
    endcase
  end

  // ==========================================================
  // State register

  // Reset is the only path that clears settings;
  // standby has no hook here on purpose.
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      s_q.addr_hi <= `UBM_RST_HALF;
      s_q.addr_lo <= `UBM_RST_HALF;
      s_q.mask_hi <= `UBM_RST_HALF; // [R03]
      s_q.mask_lo <= `UBM_RST_HALF; // [R03]
      s_q.cond    <= `UBM_RST_COND; // [R04]
      s_q.brk     <= UBM_BRK_IDLE;
      s_q.second  <= 1'b0;
      s_q.cpu_brk <= 1'b0;
      s_q.waitreq <= 1'b1;
      s_q.rdata   <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs

  assign o_readdata     = s_q.rdata;
  assign o_waitrequest  = s_q.waitreq;
  assign o_break_req    = s_q.brk == UBM_BRK_PEND; // [R13]
  assign o_cpu_break    = s_q.cpu_brk;
  assign o_break_second = s_q.second; // [R18]

endmodule : ubm_top

// *** dv/bcbm_properties.sv ***
// Port checker for the bus cycle break matcher.
// Assumes the ports of ubm_top; bound at the foot of this file.
`timescale 1ns/1ps

module bcbm_checker #(
  parameter int ADDR_W = 6
) (
  // Clock and register bus
  input wire logic              i_sys_clk,
  input wire logic              i_resetn,
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic              i_read,
  input wire logic              i_write,
  input wire logic [31:0]       o_readdata,
  input wire logic              o_waitrequest,
  // Break side
  input wire logic              i_cyc_valid,
  input wire logic [3:0]        i_mask_level,
  input wire logic              o_break_req,
  input wire logic              o_cpu_break
);
  // ==========================================================
  // Break hand-off
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_accept;
    o_break_req && i_mask_level != 4'hF;
  endsequence
  sequence s_forward;
    !o_break_req && o_cpu_break ##1 !o_cpu_break;
  endsequence
  forward_on_accept_a: assert property (s_accept |=> s_forward)
    else $error("accepted break not forwarded");
  hold_at_top_a: assert property (s_accept or o_break_req |=> o_break_req || o_cpu_break)
    else $error("pending break lost");
  pulse_has_cause_a: assert property (o_cpu_break |-> $past(o_break_req))
    else $error("break forwarded without request");
  request_has_cause_a: assert property ($rose(o_break_req) |-> $past(i_cyc_valid))
    else $error("break request without bus cycle");
  // ==========================================================
  // Register bus
  bus_answer_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("bus request not answered");
  wait_one_cycle_a: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low too long");
  unmapped_zero_a: assert property (i_read && !o_waitrequest && i_address == 'h30
    |-> o_readdata == 32'h0) else $error("unmapped read not zero");
  cond_upper_zero_a: assert property (i_read && !o_waitrequest && i_address == 'h20
    |-> o_readdata[31:8] == 24'h0) else $error("condition upper bits not zero");
endmodule : bcbm_checker

bind ubm_top bcbm_checker #(.ADDR_W(ADDR_W)) bcbm_checker_inst (
  .i_sys_clk, .i_resetn, .i_address, .i_read, .i_write, .o_readdata,
  .o_waitrequest, .i_cyc_valid, .i_mask_level, .o_break_req, .o_cpu_break
);

// *** dv/bcbm_cycle_model.sv ***
// Processor and DMA bus cycle source for the break matcher bench.
// Assumes issue() is called from one process at a time.
`timescale 1ns/1ps

module bcbm_cycle_model (
  // Clock
  input  wire logic   i_sys_clk,
  // Bus cycle seen by the matcher
  output logic        o_valid,
  output logic [31:0] o_addr,
  output logic        o_dma,
  output logic        o_fetch,
  output logic        o_write,
  output logic [1:0]  o_size,
  output logic        o_dual
);
  initial begin
    o_valid = 1'b0;
    o_addr  = 32'h0;
    {o_dma, o_fetch, o_write, o_size, o_dual} = 6'h0;
  end

  task automatic issue(input logic [31:0] a, input logic dma, fetch, wr,
                       input logic [1:0] sz, input logic dual);
    @(posedge i_sys_clk);
    o_valid <= 1'b1;
    o_addr  <= a;
    o_dma   <= dma;
    // DMA never fetches; a fetch is a read, size passed raw
    o_fetch <= fetch & ~dma;
    o_write <= wr & ~fetch;
    o_size  <= sz;
    o_dual  <= dual & fetch;
    @(posedge i_sys_clk);
    // Released bus must not look like a repeat
    o_valid <= 1'b0;
    o_addr  <= ~a;
  endtask : issue
endmodule : bcbm_cycle_model

// *** dv/bus_cycle_break_matcher_bench.sv ***
// Self-checking bench for the bus cycle break matcher.
// Assumes ubm_top, the cycle model and the bound checker are compiled.
`timescale 1ns/1ps

module bus_cycle_break_matcher_bench;
  logic        i_sys_clk, i_resetn, i_read, i_write, i_standby;
  logic        i_cyc_valid, i_cyc_dma, i_cyc_fetch, i_cyc_write, i_cyc_dual;
  logic        o_waitrequest, o_break_req, o_cpu_break, o_break_second;
  logic [1:0]  i_cyc_size;
  logic [3:0]  i_mask_level;
  logic [5:0]  i_address;
  logic [31:0] i_writedata, i_cyc_addr, o_readdata, rd;
  int          miscompares, cmp_count;

  ubm_top ubm_top_inst (
    .i_sys_clk, .i_resetn, .i_address, .i_read, .i_write, .i_byteenable(4'hF),
    .i_writedata, .o_readdata, .o_waitrequest, .i_cyc_valid, .i_cyc_addr,
    .i_cyc_dma, .i_cyc_fetch, .i_cyc_write, .i_cyc_size, .i_cyc_dual,
    .i_mask_level, .i_standby, .o_break_req, .o_cpu_break, .o_break_second
  );
  bcbm_cycle_model bcbm_cycle_model_inst (
    .i_sys_clk, .o_valid(i_cyc_valid), .o_addr(i_cyc_addr), .o_dma(i_cyc_dma),
    .o_fetch(i_cyc_fetch), .o_write(i_cyc_write), .o_size(i_cyc_size),
    .o_dual(i_cyc_dual)
  );

  // ==========================================================
  // Shared tasks
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_write     <= wr;
    i_read      <= ~wr;
    i_address   <= a;
    i_writedata <= {16'h0, d};
    for (int n = 0; n < 20 && o_waitrequest !== 1'b0; n++) @(posedge i_sys_clk);
    if (o_waitrequest !== 1'b0) begin
      miscompares++;
      complete_run();
    end
    rd = o_readdata;
    i_write <= 1'b0;
    i_read  <= 1'b0;
  endtask : bus

  task automatic prog(input logic [15:0] ah, al, c);
    bus(1'b1, 6'h00, ah);
    bus(1'b1, 6'h08, al);
    bus(1'b1, 6'h20, c);
  endtask : prog

  // Window covers request, forward and slack
  task automatic seen(input string n, input logic e);
    logic s;
    s = 1'b0;
    repeat (6) begin
      @(posedge i_sys_clk);
      s |= o_cpu_break;
    end
    chk(n, {31'h0, e}, {31'h0, s});
  endtask : seen

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, 6'(i * 8), 16'h0);
      chk("register after reset", 32'h0, rd);
    end
    $display("test reset values done");
  endtask : t_reset

  task automatic t_regs();
    i_standby <= 1'b1;
    for (int i = 0; i < 4; i++) bus(1'b1, 6'(i * 8), 16'hFFFF);
    bus(1'b1, 6'h20, 16'h00FF);
    bus(1'b1, 6'h30, 16'hFFFF);
    bus(1'b0, 6'h00, 16'h0);
    chk("address high", 32'hFFFF, rd);
    bus(1'b0, 6'h08, 16'h0);
    chk("address low", 32'hFFFF, rd);
    bus(1'b0, 6'h10, 16'h0);
    chk("mask high", 32'hFFFF, rd);
    bus(1'b0, 6'h18, 16'h0);
    chk("mask low", 32'hFFFF, rd);
    bus(1'b0, 6'h20, 16'h0);
    chk("conditions", 32'h00FF, rd);
    bus(1'b0, 6'h30, 16'h0);
    chk("unmapped", 32'h0, rd);
    i_standby <= 1'b0;
    for (int i = 0; i < 5; i++) bus(1'b1, 6'(i * 8), 16'h0);
    $display("test register access done");
  endtask : t_regs

  task automatic t_fields();
    logic [7:0] cc[13] = '{8'h6A, 8'hAA, 8'hEA, 8'h2A, 8'h5A, 8'h7A, 8'h1A,
                           8'h66, 8'h6E, 8'h62, 8'h68, 8'h69, 8'h6B};
    logic       ex[13] = '{1, 0, 1, 0, 0, 1, 0, 0, 1, 0, 1, 0, 0};
    for (int i = 0; i < 13; i++) begin
      prog(16'h0012, 16'h3456, {8'h0, cc[i]});
      bcbm_cycle_model_inst.issue(32'h0012_3456, 1'b0, 1'b0, 1'b1, 2'h2, 1'b0);
      seen("word write break", ex[i]);
    end
    prog(16'h0076, 16'hBCDC, 16'h00A7);
    bcbm_cycle_model_inst.issue(32'h0076_BCDC, 1'b1, 1'b0, 1'b0, 2'h3, 1'b0);
    seen("DMA long read break", 1'b1);
    $display("test condition fields done");
  endtask : t_fields

  task automatic t_mask();
    bus(1'b1, 6'h10, 16'h0F00);
    bus(1'b1, 6'h18, 16'h000F);
    prog(16'h0012, 16'h3456, 16'h006A);
    bcbm_cycle_model_inst.issue(32'h0F12_345A, 1'b0, 1'b0, 1'b1, 2'h2, 1'b0);
    seen("masked bits ignored", 1'b1);
    bcbm_cycle_model_inst.issue(32'h0012_3446, 1'b0, 1'b0, 1'b1, 2'h2, 1'b0);
    seen("low bit compared", 1'b0);
    bcbm_cycle_model_inst.issue(32'h1012_3456, 1'b0, 1'b0, 1'b1, 2'h2, 1'b0);
    seen("high bit compared", 1'b0);
    bus(1'b1, 6'h10, 16'h0);
    bus(1'b1, 6'h18, 16'h0);
    $display("test address mask done");
  endtask : t_mask

  task automatic t_pending();
    prog(16'h0000, 16'h0404, 16'h0056);
    bcbm_cycle_model_inst.issue(32'h0404, 1'b0, 1'b1, 1'b0, 2'h1, 1'b0);
    seen("fetch taken as word", 1'b1);
    prog(16'h0000, 16'h0404, 16'h0054);
    i_mask_level <= 4'hF;
    bcbm_cycle_model_inst.issue(32'h0402, 1'b0, 1'b1, 1'b0, 2'h2, 1'b1);
    repeat (20) @(posedge i_sys_clk);
    chk("pending at level 15", 32'h3, {30'h0, o_break_second, o_break_req});
    i_mask_level <= 4'hE;
    seen("accepted at level 14", 1'b1);
    $display("test pending break done");
  endtask : t_pending

  // ==========================================================
  // Clock and main sequence
  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    i_resetn     = 1'b0;
    i_read       = 1'b0;
    i_write      = 1'b0;
    i_standby    = 1'b0;
    i_address    = 6'h00;
    i_writedata  = 32'h0;
    i_mask_level = 4'h0;
    miscompares  = 0;
    cmp_count    = 0;
    repeat (8) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    t_reset();
    t_regs();
    t_fields();
    t_mask();
    t_pending();
    complete_run();
  end
endmodule : bus_cycle_break_matcher_bench
